/* File: logic/lptl_pkg.sv */
// constants and state type for the threshold and emitter register block
`default_nettype none
package lptl_pkg;
   // byte register addresses
   localparam logic [7:0] ADDR_AMB_LO_L = 8'h0b;
   localparam logic [7:0] ADDR_AMB_LO_H = 8'h0c;
   localparam logic [7:0] ADDR_AMB_HI_L = 8'h0d;
   localparam logic [7:0] ADDR_AMB_HI_H = 8'h0e;
   localparam logic [7:0] ADDR_EMIT_AB = 8'h0f;
   localparam logic [7:0] ADDR_EMIT_C = 8'h10;
   localparam logic [7:0] ADDR_PROX_L = 8'h11;
   localparam logic [7:0] ADDR_PROX_H = 8'h12;
   // reset values and the value read at unmapped addresses
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] CUR_OFF = 4'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // emitter field positions
   localparam int EMIT_W = 4;
   localparam int EMIT_A_LSB = 0;
   localparam int EMIT_B_LSB = 4;
   localparam int EMIT_C_LSB = 0;
   localparam logic [3:0] EMIT_C_RSVD = 4'h0;
   // compressed threshold layout: exponent high nibble, mantissa low nibble
   localparam int COMP_EXP_LSB = 4;
   localparam int COMP_MANT_W = 4;

   typedef struct packed {
      logic [7:0] amb_lo_l;
      logic [7:0] amb_lo_h;
      logic [7:0] amb_hi_l;
      logic [7:0] amb_hi_h;
      logic [7:0] emit_ab;
      logic [7:0] emit_c;
      logic [7:0] prox_l;
      logic [7:0] prox_h;
      logic [7:0] rdata;
      logic rvalid;
      logic amb_evt;
      logic prox_evt;
      logic [3:0] cur_a;
      logic [3:0] cur_b;
      logic [3:0] cur_c;
   } lptl_state_t;
endpackage
`default_nettype wire

/* File: logic/lptl_thresh_decode.sv */
// threshold byte pair to 16-bit value, plain or compressed
`timescale 1ns/1ps
`default_nettype none
module lptl_thresh_decode
(
   // threshold bytes
   input wire logic [7:0] low_i,
   input wire logic [7:0] high_i,
   // older revision selects compressed format
   input wire logic legacy_i,
   // expanded threshold
   output logic [15:0] value_o
);
   import lptl_pkg::*;

   logic [3:0] exp_w;
   logic [3:0] mant_w;
   logic [19:0] wide_w;

   always_comb
   begin
      exp_w = low_i[COMP_EXP_LSB +: 4];
      mant_w = low_i[COMP_MANT_W-1:0];
      wide_w = 20'({1'b1, mant_w}) << exp_w;
      if (!legacy_i)
      begin
         value_o = {high_i, low_i};
      end
      else if (low_i == RST_BYTE)
      begin
         value_o = 16'h0000;
      end
      else
      begin
         value_o = wide_w[19:4];
      end
   end
endmodule
`default_nettype wire

/* File: logic/lptl_regs.sv */
// threshold and emitter current registers with window and proximity compare
`timescale 1ns/1ps
`default_nettype none
module lptl_regs
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // byte register port from the serial slave
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // revision and source selection
   input wire logic legacy_rev_i,
   input wire logic amb_sel_ir_i,
   // ambient measurement results
   input wire logic [15:0] ambient_visible_result_i,
   input wire logic [15:0] ambient_infrared_result_i,
   input wire logic amb_valid_i,
   // proximity channel one measurement
   input wire logic prox_meas_active_i,
   input wire logic [15:0] prox_channel_one_result_i,
   input wire logic prox_valid_i,
   // threshold events
   output logic amb_window_evt_o,
   output logic prox_one_evt_o,
   // emitter current codes
   output logic [3:0] emitter_a_current_o,
   output logic [3:0] emitter_b_current_o,
   output logic [3:0] emitter_c_current_o
);
   import lptl_pkg::*;

   lptl_state_t q;
   lptl_state_t d;
   logic [15:0] amb_lower_w;
   logic [15:0] amb_upper_w;
   logic [15:0] prox_th_w;
   logic [15:0] amb_sample_w;

   // lower window edge
   lptl_thresh_decode u_amb_lower
   (
      .low_i(q.amb_lo_l),
      .high_i(q.amb_lo_h),
      .legacy_i(legacy_rev_i),
      .value_o(amb_lower_w)
   );

   // upper window edge
   lptl_thresh_decode u_amb_upper
   (
      .low_i(q.amb_hi_l),
      .high_i(q.amb_hi_h),
      .legacy_i(legacy_rev_i),
      .value_o(amb_upper_w)
   );

   // proximity channel one threshold
   lptl_thresh_decode u_prox_one
   (
      .low_i(q.prox_l),
      .high_i(q.prox_h),
      .legacy_i(legacy_rev_i),
      .value_o(prox_th_w)
   );

   always_comb
   begin
      d = q;
      d.rvalid = 1'b0;
      d.amb_evt = 1'b0;
      d.prox_evt = 1'b0;
      amb_sample_w = amb_sel_ir_i ? ambient_infrared_result_i : ambient_visible_result_i;

      // register writes, each byte live at once
      if (reg_wr_i)
      begin
         if (reg_addr_i == ADDR_AMB_LO_L)
         begin
            d.amb_lo_l = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_AMB_LO_H)
         begin
            d.amb_lo_h = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_AMB_HI_L)
         begin
            d.amb_hi_l = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_AMB_HI_H)
         begin
            d.amb_hi_h = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_EMIT_AB)
         begin
            d.emit_ab = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_EMIT_C)
         begin
            d.emit_c = {EMIT_C_RSVD, reg_wdata_i[EMIT_C_LSB +: EMIT_W]};
         end
         else if (reg_addr_i == ADDR_PROX_L)
         begin
            d.prox_l = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_PROX_H)
         begin
            d.prox_h = reg_wdata_i;
         end
      end

      // register reads, answered next cycle
      if (reg_rd_i)
      begin
         d.rvalid = 1'b1;
         if (reg_addr_i == ADDR_AMB_LO_L)
         begin
            d.rdata = q.amb_lo_l;
         end
         else if (reg_addr_i == ADDR_AMB_LO_H)
         begin
            d.rdata = q.amb_lo_h;
         end
         else if (reg_addr_i == ADDR_AMB_HI_L)
         begin
            d.rdata = q.amb_hi_l;
         end
         else if (reg_addr_i == ADDR_AMB_HI_H)
         begin
            d.rdata = q.amb_hi_h;
         end
         else if (reg_addr_i == ADDR_EMIT_AB)
         begin
            d.rdata = q.emit_ab;
         end
         else if (reg_addr_i == ADDR_EMIT_C)
         begin
            d.rdata = q.emit_c;
         end
         else if (reg_addr_i == ADDR_PROX_L)
         begin
            d.rdata = q.prox_l;
         end
         else if (reg_addr_i == ADDR_PROX_H)
         begin
            d.rdata = q.prox_h;
         end
         else
         begin
            d.rdata = UNMAPPED_READ;
         end
      end

      // ambient window check on selected source
      if (amb_valid_i)
      begin
         d.amb_evt = (amb_sample_w < amb_lower_w) || (amb_sample_w > amb_upper_w);
      end

      // proximity threshold check, bytes decoded plain or compressed like the ambient ones
      if (prox_valid_i)
      begin
         d.prox_evt = prox_channel_one_result_i > prox_th_w;
      end

      // emitter drive only during a proximity measurement
      if (prox_meas_active_i)
      begin
         d.cur_a = q.emit_ab[EMIT_A_LSB +: EMIT_W];
         d.cur_b = q.emit_ab[EMIT_B_LSB +: EMIT_W];
         d.cur_c = q.emit_c[EMIT_C_LSB +: EMIT_W];
      end
      else
      begin
         d.cur_a = CUR_OFF;
         d.cur_b = CUR_OFF;
         d.cur_c = CUR_OFF;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         q.amb_lo_l <= RST_BYTE;
         q.amb_lo_h <= RST_BYTE;
         q.amb_hi_l <= RST_BYTE;
         q.amb_hi_h <= RST_BYTE;
         q.emit_ab <= RST_BYTE;
         q.emit_c <= RST_BYTE;
         q.prox_l <= RST_BYTE;
         q.prox_h <= RST_BYTE;
         q.rdata <= RST_BYTE;
         q.rvalid <= 1'b0;
         q.amb_evt <= 1'b0;
         q.prox_evt <= 1'b0;
         q.cur_a <= CUR_OFF;
         q.cur_b <= CUR_OFF;
         q.cur_c <= CUR_OFF;
      end
      else
      begin
         q <= d;
      end
   end

   // outputs straight from state
   assign reg_rdata_o = q.rdata;
   assign reg_rvalid_o = q.rvalid;
   assign amb_window_evt_o = q.amb_evt;
   assign prox_one_evt_o = q.prox_evt;
   assign emitter_a_current_o = q.cur_a;
   assign emitter_b_current_o = q.cur_b;
   assign emitter_c_current_o = q.cur_c;
endmodule
`default_nettype wire

/* File: testbench/lptl_regs_asserts.sv */
// port assertions for the threshold and emitter register block
`timescale 1ns/1ps
`default_nettype none
module lptl_regs_asserts
(
   // clock, reset and register port
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // measurements, events and currents
   input wire logic prox_meas_active_i,
   input wire logic amb_valid_i,
   input wire logic prox_valid_i,
   input wire logic amb_window_evt_o,
   input wire logic prox_one_evt_o,
   input wire logic [3:0] emitter_a_current_o,
   input wire logic [3:0] emitter_b_current_o,
   input wire logic [3:0] emitter_c_current_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_wr_ab;
      reg_wr_i && reg_addr_i == 8'h0f ##1 prox_meas_active_i && !reg_wr_i;
   endsequence
   property p_rst;
      disable iff (1'b0) !rst_b_i |=> !reg_rvalid_o && !prox_one_evt_o && !amb_window_evt_o;
   endproperty
   property p_rd; reg_rd_i |=> reg_rvalid_o; endproperty
   property p_idle; !reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o); endproperty
   property p_rsvd; reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o[7:4] == 4'h0; endproperty
   property p_ab;
      s_wr_ab |=> {emitter_b_current_o, emitter_a_current_o} == $past(reg_wdata_i, 2);
   endproperty
   property p_off;
      !prox_meas_active_i |=> {emitter_a_current_o, emitter_b_current_o, emitter_c_current_o} == 12'h0;
   endproperty
   property p_pq; !prox_valid_i |=> !prox_one_evt_o; endproperty
   property p_aq; !amb_valid_i |=> !amb_window_evt_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   a_rd: assert property (p_rd) else $error("no read answer");
   a_idle: assert property (p_idle) else $error("stray read answer");
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   a_ab: assert property (p_ab) else $error("emitter a or b current");
   a_off: assert property (p_off) else $error("current while idle");
   a_pq: assert property (p_pq) else $error("stray prox event");
   a_aq: assert property (p_aq) else $error("stray ambient event");
endmodule
bind lptl_regs lptl_regs_asserts u_chk (.*);
`default_nettype wire

/* File: testbench/lptl_host.sv */
// host model on the byte register port
`timescale 1ns/1ps
`default_nettype none
module lptl_host
(
   // clock and read data
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   // strobes, address and data
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0
);
   // one byte access; bus shows inverse once released
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= w;
      rd_o <= !w;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      #1 q = rdata_i;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// testbench for the threshold and emitter register block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lptl_pkg::*;
   logic sys_clk_i, rst_b_i = 1'b0, wr, rd, rv, leg = 1'b0, ir_sel = 1'b0;
   logic av = 1'b0, act = 1'b0, pv = 1'b0, aevt, pevt;
   logic [7:0] addr, wd, rdat, q;
   logic [15:0] vis = 16'h0, irr = 16'h0, pres = 16'h0;
   logic [3:0] ca, cb, cc;
   int failures = 0, check_count = 0;
   lptl_host h (.clk_i(sys_clk_i), .rdata_i(rdat), .addr_o(addr), .wdata_o(wd), .wr_o(wr),
      .rd_o(rd));
   lptl_regs DUT (.sys_clk_i, .rst_b_i, .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .legacy_rev_i(leg),
      .amb_sel_ir_i(ir_sel), .ambient_visible_result_i(vis), .ambient_infrared_result_i(irr),
      .amb_valid_i(av), .prox_meas_active_i(act), .prox_channel_one_result_i(pres),
      .prox_valid_i(pv), .amb_window_evt_o(aevt), .prox_one_evt_o(pevt),
      .emitter_a_current_o(ca), .emitter_b_current_o(cb), .emitter_c_current_o(cc));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wb(input logic [7:0] a, input logic [7:0] d);
      h.acc(1'b1, a, d, q);
      chk("rvalid", 16'h0000, {15'h0, rv});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      h.acc(1'b0, a, 8'h00, q);
      chk("rdata", {8'h0, e}, {8'h0, q});
      chk("rvalid", 16'h0001, {15'h0, rv});
   endtask
   // one result pulse on the prox (p) or ambient path
   task automatic ms(input logic p, input logic [15:0] r, input logic [15:0] i, input logic e);
      @(posedge sys_clk_i);
      pv <= p;
      av <= !p;
      pres <= r;
      vis <= r;
      irr <= i;
      @(posedge sys_clk_i);
      pv <= 1'b0;
      av <= 1'b0;
      pres <= ~r;
      vis <= ~r;
      #1 chk("event", {15'h0, e}, {15'h0, p ? pevt : aevt});
   endtask
   task automatic t_regs;
      for (int i = 11; i < 20; i++)
         rc(8'(i), 8'h00);
      for (int i = 11; i < 19; i++)
         wb(8'(i), 8'(i) ^ 8'ha5);
      for (int i = 11; i < 19; i++)
         rc(8'(i), (8'(i) ^ 8'ha5) & (i == 16 ? 8'h0f : 8'hff));
      wb(8'h20, 8'hff);
      rc(8'h20, 8'h00);
      $display("register map done");
   endtask
   task automatic t_emit;
      wb(8'h0f, 8'h21);
      wb(8'h10, 8'hff);
      @(posedge sys_clk_i);
      act <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("cur", 16'h12f, {4'h0, ca, cb, cc});
      wb(8'h0f, 8'hf0);
      @(posedge sys_clk_i);
      #1 chk("cur", 16'h0ff, {4'h0, ca, cb, cc});
      @(posedge sys_clk_i);
      act <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("cur", 16'h000, {4'h0, ca, cb, cc});
      $display("emitters done");
   endtask
   task automatic t_thr;
      wb(8'h11, 8'h00);
      wb(8'h12, 8'h01);
      ms(1'b1, 16'h0100, 16'h0, 1'b0);
      ms(1'b1, 16'h0101, 16'h0, 1'b1);
      wb(8'h12, 8'h00);
      ms(1'b1, 16'h0001, 16'h0, 1'b1);
      wb(8'h0b, 8'h10);
      wb(8'h0c, 8'h00);
      wb(8'h0d, 8'h00);
      wb(8'h0e, 8'h01);
      ms(1'b0, 16'h0100, 16'hffff, 1'b0);
      ms(1'b0, 16'h0101, 16'h0000, 1'b1);
      ms(1'b0, 16'h000f, 16'h0050, 1'b1);
      @(posedge sys_clk_i);
      ir_sel <= 1'b1;
      ms(1'b0, 16'h0050, 16'h0200, 1'b1);
      ms(1'b0, 16'h0000, 16'h0010, 1'b0);
      $display("thresholds done");
   endtask
   task automatic t_leg;
      @(posedge sys_clk_i);
      leg <= 1'b1;
      ir_sel <= 1'b0;
      wb(8'h11, 8'h10);
      wb(8'h0d, 8'h40);
      ms(1'b1, 16'h0002, 16'h0, 1'b0);
      ms(1'b1, 16'h0003, 16'h0, 1'b1);
      ms(1'b0, 16'h0010, 16'h0, 1'b0);
      ms(1'b0, 16'h0011, 16'h0, 1'b1);
      $display("compressed thresholds done");
   endtask
   // mid-run reset must clear every byte written before it
   task automatic t_rst;
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      for (int i = 11; i < 19; i++)
         rc(8'(i), 8'h00);
      $display("reset clear done");
   endtask
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #100000;
      failures++;
      end_of_test();
   end
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_emit();
      t_thr();
      t_leg();
      t_rst();
      end_of_test();
   end
endmodule
`default_nettype wire
